// ### reg_supervisor_pkg.sv
// constants for the buck-boost mode and fault supervisor
// assumes a 125 MHz device clock; times are held in microseconds
package reg_supervisor_pkg;
    localparam int CLK_MHZ = 125;                      // device clock rate
    localparam int ADP_OV_TRIP_US = 10;                // input overvoltage trip
    localparam int QUAL_100US = 100;                   // recovery and ov qualification
    localparam int UV_TRIP_US = 1000;                  // undervoltage trip
    localparam int DEB_LONG_US = 1300000;              // long pin debounce
    localparam int DEB_SHORT_US = 150000;              // short pin debounce
    localparam int ADP_OV_TRIP_CYC = ADP_OV_TRIP_US * CLK_MHZ;
    localparam int QUAL_100US_CYC = QUAL_100US * CLK_MHZ;
    localparam int UV_TRIP_CYC = UV_TRIP_US * CLK_MHZ;
    localparam int DEB_LONG_CYC = DEB_LONG_US * CLK_MHZ;
    localparam int DEB_SHORT_CYC = DEB_SHORT_US * CLK_MHZ;
    // register offsets
    localparam logic [7:0] FWD_SETPOINT_ADDR = 8'h15;
    localparam logic [7:0] REV_SETPOINT_ADDR = 8'h49;
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h3C;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h3D;
    // setpoint field (bits 14:3), values in mV with 8 mV steps
    localparam logic [15:0] SETPOINT_MASK = 16'h7FF8;
    localparam logic [15:0] REV_SETPOINT_RST = 16'h1388;   // 5 V
    localparam logic [15:0] FWD_SETPOINT_RST = 16'h1388;   // plain default
    localparam logic [15:0] SETPOINT_MAX = 16'h4E20;       // 20 V
    localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
    localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
    // field positions
    localparam int C1_FAST_REF = 3;
    localparam int C1_FORCE_DAC = 5;
    localparam int C1_FORCE_REV = 11;
    localparam int C1_SKIP_AZ = 12;
    localparam int C1_SKIP_TRIM = 13;
    localparam int C2_REV_SWAP = 4;
    localparam int C2_FWD_SWAP = 5;
    localparam int C2_DEB_SHORT = 13;
    // fault indices
    localparam int F_ADP_IN_OV = 0;
    localparam int F_SYS_OV = 1;
    localparam int F_SYS_UV = 2;
    localparam int F_ADP_OV = 3;
    localparam int F_ADP_UV = 4;
    localparam int F_OT = 5;
    localparam int NUM_FAULTS = 6;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REV_WAIT = 2'b01,
        ST_REV = 2'b11,
        ST_FWD = 2'b10
    } mode_t;
endpackage

// ### regulator_mode_fault_supervisor.sv
// mode control, fast-swap flags and protection for a buck-boost regulator
// comparator and pin inputs are asynchronous; register writes arrive on linkClock
`timescale 1ns/1ns
`default_nettype none
module regulator_mode_fault_supervisor #(
    parameter int QUAL_CYC = reg_supervisor_pkg::QUAL_100US_CYC,
    parameter int UV_CYC = reg_supervisor_pkg::UV_TRIP_CYC,
    parameter int DEB_LONG = reg_supervisor_pkg::DEB_LONG_CYC,
    parameter int DEB_SHORT = reg_supervisor_pkg::DEB_SHORT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic linkClock,
    input wire logic regWriteStrobe,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic reverseEnablePin,
    input wire logic forwardEnablePin,
    input wire logic forwardEnableInput,
    input wire logic sysAbove4v1,
    input wire logic adpAbove4v1,
    input wire logic adpSideBelowOv,
    input wire logic adpInOver,
    input wire logic adpInBelowRecover,
    input wire logic sysOverTrip,
    input wire logic sysOverClear,
    input wire logic sysUnderTrip,
    input wire logic adpOverTrip,
    input wire logic adpOverClear,
    input wire logic adpUnderTrip,
    input wire logic tempHot,
    input wire logic tempCool,
    input wire logic fwdInRange,
    input wire logic revInRange,
    output logic switchEnable,
    output logic reverseMode,
    output logic forwardPowerGood,
    output logic reversePowerGood,
    output logic fastRefEnable,
    output logic forceDac,
    output logic skipTrim,
    output logic skipAutozero,
    output logic reverseFastSwap,
    output logic forwardFastSwap,
    output logic [15:0] forwardSetpoint,
    output logic [15:0] reverseSetpoint,
    output logic [5:0] faultStatus
);
    localparam int NSYNC = 18;
    localparam logic [27:0] DEB_L = 28'(DEB_LONG);
    localparam logic [27:0] DEB_S = 28'(DEB_SHORT);

    // link domain reset, two stages so release is clean
    logic [1:0] linkRstQ;
    always_ff @(posedge linkClock) begin
        linkRstQ <= {linkRstQ[0], rst};
    end

    // link side write capture; held data stays stable until the next write
    logic [7:0] wrAddrQ;
    logic [15:0] wrDataQ;
    logic wrToggleQ;
    always_ff @(posedge linkClock) begin
        if (linkRstQ[1]) begin
            wrAddrQ <= 8'h00;
            wrDataQ <= 16'h0000;
            wrToggleQ <= 1'b0;
        end else if (regWriteStrobe) begin
            wrAddrQ <= regAddr;
            wrDataQ <= regWriteData;
            wrToggleQ <= ~wrToggleQ;
        end
    end

    // toggle crossing plus a third stage used only for the edge detect
    logic [2:0] wrTogSyncQ;
    logic wrEvent;
    always_ff @(posedge clock) begin
        if (rst) begin
            wrTogSyncQ <= 3'b000;
        end else begin
            wrTogSyncQ <= {wrTogSyncQ[1:0], wrToggleQ};
        end
    end
    assign wrEvent = wrTogSyncQ[2] ^ wrTogSyncQ[1];

    // two-stage synchronisers for every pin and comparator
    logic [NSYNC-1:0] rawIn, syncAQ, syncBQ;
    assign rawIn = {reverseEnablePin, forwardEnablePin, forwardEnableInput, sysAbove4v1,
        adpAbove4v1, adpSideBelowOv, adpInOver, adpInBelowRecover, sysOverTrip,
        sysOverClear, sysUnderTrip, adpOverTrip, adpOverClear, adpUnderTrip, tempHot,
        tempCool, fwdInRange, revInRange};
    always_ff @(posedge clock) begin
        if (rst) begin
            syncAQ <= '0;
            syncBQ <= '0;
        end else begin
            syncAQ <= rawIn;
            syncBQ <= syncAQ;
        end
    end
    logic revPinS, fwdPinS, fwdInS, sysOkS, adpOkS, csipOkS;
    logic adpInOvS, adpInRecS, sysOvS, sysOvClrS, sysUvS, adpOvS, adpOvClrS, adpUvS;
    logic hotS, coolS, fwdRangeS, revRangeS;
    assign {revPinS, fwdPinS, fwdInS, sysOkS, adpOkS, csipOkS, adpInOvS, adpInRecS,
        sysOvS, sysOvClrS, sysUvS, adpOvS, adpOvClrS, adpUvS, hotS, coolS, fwdRangeS,
        revRangeS} = syncBQ;

    // register file; setpoints keep only bits 14:3
    logic [15:0] ctrlOneQ, ctrlTwoQ, fwdSetQ, revSetQ, wrMasked;
    assign wrMasked = wrDataQ & reg_supervisor_pkg::SETPOINT_MASK;
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrlOneQ <= reg_supervisor_pkg::CTRL_ONE_RST;
            ctrlTwoQ <= reg_supervisor_pkg::CTRL_TWO_RST;
            fwdSetQ <= reg_supervisor_pkg::FWD_SETPOINT_RST;
            revSetQ <= reg_supervisor_pkg::REV_SETPOINT_RST; // 5 V after reset
        end else if (wrEvent) begin
            case (wrAddrQ)
                reg_supervisor_pkg::CTRL_ONE_ADDR: ctrlOneQ <= wrDataQ;
                reg_supervisor_pkg::CTRL_TWO_ADDR: ctrlTwoQ <= wrDataQ;
                reg_supervisor_pkg::FWD_SETPOINT_ADDR: fwdSetQ <= wrMasked;
                reg_supervisor_pkg::REV_SETPOINT_ADDR: begin
                    // clamp to 20 V in every reverse sub-mode
                    revSetQ <= (wrMasked > reg_supervisor_pkg::SETPOINT_MAX) ?
                        reg_supervisor_pkg::SETPOINT_MAX : wrMasked;
                end
                default: ; // unmapped writes are dropped
            endcase
        end
    end

    // control outputs from flops; sequencing of these bits is the host's job
    always_ff @(posedge clock) begin
        if (rst) begin
            fastRefEnable <= 1'b0;
            forceDac <= 1'b0;
            skipTrim <= 1'b0;
            skipAutozero <= 1'b0;
            reverseFastSwap <= 1'b0;
            forwardFastSwap <= 1'b0;
            forwardSetpoint <= reg_supervisor_pkg::FWD_SETPOINT_RST;
            reverseSetpoint <= reg_supervisor_pkg::REV_SETPOINT_RST;
        end else begin
            fastRefEnable <= ctrlOneQ[reg_supervisor_pkg::C1_FAST_REF]; // 5k path
            forceDac <= ctrlOneQ[reg_supervisor_pkg::C1_FORCE_DAC];
            skipTrim <= ctrlOneQ[reg_supervisor_pkg::C1_SKIP_TRIM];
            skipAutozero <= ctrlOneQ[reg_supervisor_pkg::C1_SKIP_AZ];
            reverseFastSwap <= ctrlTwoQ[reg_supervisor_pkg::C2_REV_SWAP];
            forwardFastSwap <= ctrlTwoQ[reg_supervisor_pkg::C2_FWD_SWAP];
            forwardSetpoint <= fwdSetQ;
            reverseSetpoint <= revSetQ;
        end
    end

    // reverse pin debounce: counter restarts whenever the pin bounces back
    logic revPinDebQ;
    logic [27:0] debCntQ, debLimit;
    assign debLimit = ctrlTwoQ[reg_supervisor_pkg::C2_DEB_SHORT] ? DEB_S : DEB_L;
    always_ff @(posedge clock) begin
        if (rst) begin
            revPinDebQ <= 1'b0;
            debCntQ <= 28'h0000000;
        end else if (revPinS == revPinDebQ) begin
            debCntQ <= 28'h0000000;
        end else if (debCntQ >= debLimit - 28'h0000001) begin
            revPinDebQ <= revPinS;
            debCntQ <= 28'h0000000;
        end else begin
            debCntQ <= debCntQ + 28'h0000001;
        end
    end

    // fault qualifiers: trip and recovery counters restart on lapse
    logic [5:0] tripC, clearC, faultQ;
    logic [16:0] tripLim [6];
    logic [16:0] clearLim [6];
    logic [16:0] qCntQ [6];
    reg_supervisor_pkg::mode_t stateQ, stateD;
    logic fwdAct, revAct;
    assign fwdAct = (stateQ == reg_supervisor_pkg::ST_FWD);
    assign revAct = (stateQ == reg_supervisor_pkg::ST_REV);
    assign tripC = {hotS, adpUvS & revAct, adpOvS, sysUvS & fwdAct, sysOvS, adpInOvS};
    assign clearC = {coolS, ~adpUvS, adpOvClrS, ~sysUvS, sysOvClrS, adpInRecS};
    assign tripLim[0] = 17'(reg_supervisor_pkg::ADP_OV_TRIP_CYC); // 10us
    assign tripLim[1] = 17'(QUAL_CYC);
    assign tripLim[2] = 17'(UV_CYC);
    assign tripLim[3] = 17'(QUAL_CYC);
    assign tripLim[4] = 17'(UV_CYC);
    assign tripLim[5] = 17'h00001; // immediate thermal stop
    assign clearLim[0] = 17'(QUAL_CYC);
    assign clearLim[1] = 17'(QUAL_CYC);
    assign clearLim[2] = 17'h00001; // uv restarts the sequence at once
    assign clearLim[3] = 17'(QUAL_CYC);
    assign clearLim[4] = 17'h00001;
    assign clearLim[5] = 17'(QUAL_CYC);
    for (genvar i = 0; i < reg_supervisor_pkg::NUM_FAULTS; i++) begin : g_fault
        logic cond;
        logic [16:0] lim;
        assign cond = faultQ[i] ? clearC[i] : tripC[i];
        assign lim = faultQ[i] ? clearLim[i] : tripLim[i];
        always_ff @(posedge clock) begin
            if (rst) begin
                faultQ[i] <= 1'b0;
                qCntQ[i] <= 17'h00000;
            end else if (!cond) begin
                qCntQ[i] <= 17'h00000;
            end else if (qCntQ[i] >= lim - 17'h00001) begin
                faultQ[i] <= ~faultQ[i];
                qCntQ[i] <= 17'h00000;
            end else begin
                qCntQ[i] <= qCntQ[i] + 17'h00001;
            end
        end
    end
    assign faultStatus = faultQ;

    // mode state machine; reverse takes priority over forward
    logic revReq, fwdReq;
    assign revReq = (ctrlOneQ[reg_supervisor_pkg::C1_FORCE_REV] | revPinDebQ) & sysOkS;
    assign fwdReq = (fwdPinS | fwdInS) & adpOkS;
    always_comb begin
        stateD = stateQ;
        case (stateQ)
            reg_supervisor_pkg::ST_IDLE: begin
                if (revReq) stateD = reg_supervisor_pkg::ST_REV_WAIT;
                else if (fwdReq) stateD = reg_supervisor_pkg::ST_FWD;
            end
            reg_supervisor_pkg::ST_REV_WAIT: begin
                if (!revReq) stateD = reg_supervisor_pkg::ST_IDLE;
                else if (csipOkS) stateD = reg_supervisor_pkg::ST_REV; // wait below ov threshold
            end
            reg_supervisor_pkg::ST_REV: begin
                if (!revReq) stateD = reg_supervisor_pkg::ST_IDLE;
            end
            reg_supervisor_pkg::ST_FWD: begin
                // uv fault sends forward back through the start sequence
                if (!fwdReq || revReq || faultQ[reg_supervisor_pkg::F_SYS_UV]) begin
                    stateD = reg_supervisor_pkg::ST_IDLE;
                end
            end
            default: stateD = reg_supervisor_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) stateQ <= reg_supervisor_pkg::ST_IDLE;
        else stateQ <= stateD;
    end

    // switching gate and power good flags from flops
    always_ff @(posedge clock) begin
        if (rst) begin
            switchEnable <= 1'b0;
            reverseMode <= 1'b0;
            forwardPowerGood <= 1'b0;
            reversePowerGood <= 1'b0;
        end else begin
            switchEnable <= (stateD == reg_supervisor_pkg::ST_FWD || stateD == reg_supervisor_pkg::ST_REV)
                && ~|faultQ;
            reverseMode <= (stateD == reg_supervisor_pkg::ST_REV)
                || (stateD == reg_supervisor_pkg::ST_REV_WAIT);
            forwardPowerGood <= fwdAct && fwdRangeS && ~|faultQ;
            reversePowerGood <= revAct && revRangeS && ~|faultQ;
        end
    end

    // checks
    property p_rev_req; @(posedge clock) disable iff (rst)
        (stateQ == reg_supervisor_pkg::ST_REV) |-> $past(revReq, 1);
    endproperty
    a_rev_req: assert property (p_rev_req) else $error("reverse without request");
    property p_rev_wait; @(posedge clock) disable iff (rst)
        (stateQ == reg_supervisor_pkg::ST_REV_WAIT && !csipOkS) |=> (stateQ != reg_supervisor_pkg::ST_REV);
    endproperty
    a_rev_wait: assert property (p_rev_wait) else $error("reverse began above ov");
    property p_fault_gate; @(posedge clock) disable iff (rst)
        (|faultQ) |=> !switchEnable;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("switching while faulted");
    property p_fwd_pg; @(posedge clock) disable iff (rst)
        // the flag is registered, so it may trail a new fault by one cycle
        forwardPowerGood |-> $past(fwdRangeS) && !$past(faultQ[1]) && !$past(faultQ[2]);
    endproperty
    a_fwd_pg: assert property (p_fwd_pg) else $error("forward good while faulted");
    property p_rev_pg; @(posedge clock) disable iff (rst)
        reversePowerGood |-> $past(revRangeS) && $past(revAct) && !$past(faultQ[3]);
    endproperty
    a_rev_pg: assert property (p_rev_pg) else $error("reverse good too early");
    property p_adp_trip; @(posedge clock) disable iff (rst)
        $rose(faultQ[0]) |-> $past(qCntQ[0]) == tripLim[0] - 17'h00001 && $past(adpInOvS);
    endproperty
    a_adp_trip: assert property (p_adp_trip) else $error("input ov tripped early");
    property p_ot_rec; @(posedge clock) disable iff (rst)
        $fell(faultQ[5]) |-> $past(qCntQ[5]) == clearLim[5] - 17'h00001 && $past(coolS);
    endproperty
    a_ot_rec: assert property (p_ot_rec) else $error("thermal restart early");
    property p_deb; @(posedge clock) disable iff (rst)
        // limit taken from the same cycle as the count, as a write may move it
        $changed(revPinDebQ) |-> $past(debCntQ) == $past(debLimit) - 28'h0000001;
    endproperty
    a_deb: assert property (p_deb) else $error("pin debounce too short");
    property p_rev_max; @(posedge clock) disable iff (rst)
        revSetQ <= reg_supervisor_pkg::SETPOINT_MAX;
    endproperty
    a_rev_max: assert property (p_rev_max) else $error("reverse setpoint above 20V");
    c_rev: cover property (@(posedge clock) disable iff (rst) stateQ == reg_supervisor_pkg::ST_REV);
    c_fwd: cover property (@(posedge clock) disable iff (rst) forwardPowerGood);
    c_ot: cover property (@(posedge clock) disable iff (rst) $fell(faultQ[5]));
endmodule
`default_nettype wire

// ### host_link_model.sv
// host side of the register write link: one 16-bit word per strobe
// assumes the supervisor takes the strobe on a rising linkClock edge
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
    input wire logic linkClock,
    output logic regWriteStrobe,
    output logic [7:0] regAddr,
    output logic [15:0] regWriteData
);
    // idle bus never shows a stale copy of the last word
    initial begin
        regWriteStrobe = 1'b0;
        regAddr = 8'hFF;
        regWriteData = 16'hFFFF;
    end
    // one-cycle strobe, then spacing so the toggle crossing never loses a word
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge linkClock);
        #1;
        regWriteStrobe = 1'b1;
        regAddr = a;
        regWriteData = d;
        @(posedge linkClock);
        #1;
        regWriteStrobe = 1'b0;
        regAddr = ~a;
        regWriteData = ~d;
        repeat (9) @(posedge linkClock);
    endtask
endmodule
`default_nettype wire

// ### regulator_mode_fault_supervisor_tb.sv
// self-checking bench for the mode and fault supervisor
// assumes shortened qualifier counts; comparators are ideal levels
`timescale 1ns/1ns
`default_nettype none
module regulator_mode_fault_supervisor_tb;
    logic clock = 1'b0, linkClock = 1'b0, rst = 1'b1;
    logic reverseEnablePin = 1'b0, forwardEnablePin = 1'b0, forwardEnableInput = 1'b0;
    logic sysAbove4v1 = 1'b0, adpAbove4v1 = 1'b0, adpSideBelowOv = 1'b0;
    logic adpInOver = 1'b0, adpInBelowRecover = 1'b1, sysOverTrip = 1'b0, sysOverClear = 1'b1;
    logic sysUnderTrip = 1'b0, adpOverTrip = 1'b0, adpOverClear = 1'b1, adpUnderTrip = 1'b0;
    logic tempHot = 1'b0, tempCool = 1'b1, fwdInRange = 1'b0, revInRange = 1'b0;
    logic regWriteStrobe;
    logic [7:0] regAddr;
    logic [15:0] regWriteData, forwardSetpoint, reverseSetpoint, seed, c1, c2, d;
    logic switchEnable, reverseMode, forwardPowerGood, reversePowerGood, fastRefEnable;
    logic forceDac, skipTrim, skipAutozero, reverseFastSwap, forwardFastSwap;
    logic [5:0] faultStatus;
    int numErrors = 0;
    int comparisons = 0;

    // device clock 8 ns; link clock 15 ns with its own phase
    always #4 clock = ~clock;
    always begin
        #8 linkClock = 1'b1;
        #7 linkClock = 1'b0;
    end

    // short counts keep the run brief; expectations use the same figures
    regulator_mode_fault_supervisor #(.QUAL_CYC(20), .UV_CYC(50), .DEB_LONG(40), .DEB_SHORT(10)) u_dut (
        .clock, .rst, .linkClock, .regWriteStrobe, .regAddr, .regWriteData, .reverseEnablePin,
        .forwardEnablePin, .forwardEnableInput, .sysAbove4v1, .adpAbove4v1, .adpSideBelowOv,
        .adpInOver, .adpInBelowRecover, .sysOverTrip, .sysOverClear, .sysUnderTrip, .adpOverTrip,
        .adpOverClear, .adpUnderTrip, .tempHot, .tempCool, .fwdInRange, .revInRange, .switchEnable,
        .reverseMode, .forwardPowerGood, .reversePowerGood, .fastRefEnable, .forceDac, .skipTrim,
        .skipAutozero, .reverseFastSwap, .forwardFastSwap, .forwardSetpoint, .reverseSetpoint,
        .faultStatus);
    host_link_model u_host (.linkClock, .regWriteStrobe, .regAddr, .regWriteData);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // control bits as they should appear on the flag outputs
    function automatic logic [5:0] ctrlExp(input logic [15:0] a, input logic [15:0] b);
        return {a[3], a[5], a[13], a[12], b[4], b[5]};
    endfunction
    function automatic logic [15:0] revExp(input logic [15:0] v);
        v = v & reg_supervisor_pkg::SETPOINT_MASK;
        return (v > reg_supervisor_pkg::SETPOINT_MAX) ? reg_supervisor_pkg::SETPOINT_MAX : v;
    endfunction

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write then let the crossing land
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        u_host.write(a, v);
        step(8);
    endtask
    // trip level and its recovery level move together, as a real rail would
    task automatic setCond(input int i, input logic v);
        case (i)
            0: begin adpInOver = v; adpInBelowRecover = !v; end
            1: begin sysOverTrip = v; sysOverClear = !v; end
            2: sysUnderTrip = v;
            3: begin adpOverTrip = v; adpOverClear = !v; end
            4: adpUnderTrip = v;
            default: begin tempHot = v; tempCool = !v; end
        endcase
    endtask
    // trip, hold off, recover; checks past each count, and just short of those above 8
    task automatic faultCycle(input int i, input int tripN, input int clrN, input logic pgDrop);
        setCond(i, 1'b1);
        if (tripN > 8) begin
            step(tripN - 4);
            chk("fault early", 16'h0, faultStatus[i]);
        end
        step(12);
        chk("fault set", 16'h1, faultStatus[i]);
        chk("switch off", 16'h0, switchEnable);
        if (pgDrop) chk("pg drop", 16'h0, {forwardPowerGood, reversePowerGood});
        setCond(i, 1'b0);
        if (clrN > 8) begin
            step(clrN - 6);
            chk("fault held", 16'h1, faultStatus[i]);
            chk("held off", 16'h0, switchEnable);
        end
        step(20);
        chk("fault clear", 16'h0, faultStatus[i]);
        chk("switch back", 16'h1, switchEnable);
    endtask
    task automatic end_sim;
        $display("errors %0d comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 16'h0045;
        step(6);
        chk("rst setpoint", 16'h1388, reverseSetpoint);
        chk("rst out", 16'h0, {faultStatus, switchEnable, reverseMode});
        rst = 1'b0;
        step(10);
        wr(reg_supervisor_pkg::REV_SETPOINT_ADDR, 16'h5000);
        chk("rev clamp", 16'h4E20, reverseSetpoint);
        wr(reg_supervisor_pkg::FWD_SETPOINT_ADDR, 16'hFFFF);
        wr(8'h00, 16'h1234);
        chk("fwd mask", 16'h7FF8, forwardSetpoint);
        chk("unmapped", 16'h4E20, reverseSetpoint);
        // random control words and setpoints, reverse request kept off
        repeat (4) begin
            seed = lfsr(seed);
            c1 = seed & 16'hF7FF;
            seed = lfsr(seed);
            c2 = seed;
            seed = lfsr(seed);
            d = seed & 16'h7FFF;
            wr(reg_supervisor_pkg::CTRL_ONE_ADDR, c1);
            wr(reg_supervisor_pkg::CTRL_TWO_ADDR, c2);
            wr(reg_supervisor_pkg::REV_SETPOINT_ADDR, d);
            chk("ctrl bits", ctrlExp(c1, c2), {fastRefEnable, forceDac, skipTrim, skipAutozero,
                reverseFastSwap, forwardFastSwap});
            chk("rev setpoint", revExp(d), reverseSetpoint);
        end
        adpAbove4v1 = 1'b1;
        forwardEnablePin = 1'b1;
        fwdInRange = 1'b1;
        step(12);
        chk("fwd on", 16'h3, {switchEnable, forwardPowerGood});
        // a lapse must restart the input overvoltage count
        repeat (2) begin
            setCond(0, 1'b1);
            step(1000);
            setCond(0, 1'b0);
            step(10);
        end
        chk("lapse", 16'h0, faultStatus[0]);
        faultCycle(0, reg_supervisor_pkg::ADP_OV_TRIP_CYC, 20, 1'b0);
        faultCycle(1, 20, 20, 1'b1);
        faultCycle(2, 50, 1, 1'b1);
        faultCycle(5, 1, 20, 1'b0);
        forwardEnablePin = 1'b0;
        step(12);
        chk("fwd off", 16'h0, switchEnable);
        wr(reg_supervisor_pkg::CTRL_TWO_ADDR, 16'h0000);
        wr(reg_supervisor_pkg::CTRL_ONE_ADDR, 16'h3028);
        wr(reg_supervisor_pkg::CTRL_ONE_ADDR, 16'h3828);
        chk("no sys rail", 16'h0, reverseMode);
        sysAbove4v1 = 1'b1;
        step(12);
        chk("rev wait", 16'h2, {reverseMode, switchEnable});
        adpSideBelowOv = 1'b1;
        step(12);
        chk("rev on", 16'h6, {reverseMode, switchEnable, reversePowerGood});
        revInRange = 1'b1;
        step(12);
        chk("rev pg", 16'h1, reversePowerGood);
        faultCycle(3, 20, 20, 1'b1);
        faultCycle(4, 50, 1, 1'b1);
        wr(reg_supervisor_pkg::CTRL_ONE_ADDR, 16'h3028);
        chk("rev off", 16'h0, reverseMode);
        wr(reg_supervisor_pkg::CTRL_TWO_ADDR, 16'h0010);
        wr(reg_supervisor_pkg::CTRL_ONE_ADDR, 16'h3000);
        reverseEnablePin = 1'b1;
        step(30);
        chk("long early", 16'h0, reverseMode);
        step(20);
        chk("long done", 16'h3, {reverseMode, reverseFastSwap});
        reverseEnablePin = 1'b0;
        step(60);
        wr(reg_supervisor_pkg::CTRL_TWO_ADDR, 16'h2010);
        chk("pin off", 16'h0, reverseMode);
        reverseEnablePin = 1'b1;
        step(5);
        chk("short early", 16'h0, reverseMode);
        step(20);
        chk("short done", 16'h1, reverseMode);
        wr(reg_supervisor_pkg::CTRL_TWO_ADDR, 16'h0020);
        reverseEnablePin = 1'b0;
        step(60);
        forwardEnableInput = 1'b1;
        step(12);
        chk("fwd swap", 16'h3, {reverseMode, switchEnable, forwardFastSwap});
        end_sim();
    end

    // hang guard: the sequence needs just under a tenth of this span
    initial begin
        #400000;
        numErrors++;
        end_sim();
    end
endmodule
`default_nettype wire
